// ===== verilog/slb_pkg.sv
// Operation
// RULE1: no flag clearing in break unless enabled
// RULE2: flags cleared in break stay cleared
// RULE3: early first step cannot clear during break
// RULE4: wait or stop clears interrupt mask
// RULE5: wait stops cpu clocks, peripherals run
// RULE6: wait wake stacks one cycle after
// RULE7: reset or break also leave wait
// RULE8: break exit from wait/stop sets flag
// RULE9: watchdog runs in wait unless disabled
// RULE10: stop resets counter, disables clock output
// RULE11: stop exit stacks after recovery time
// RULE12: recovery 4096 cycles, or 32 if short
// RULE13: counter held until recovery, then times it
// RULE14: crystal systems keep short recovery clear
// RULE15: write zero or reset clears exit flag
// RULE16: reading reset cause clears all flags
// RULE17: power-on sets only its own flag
// RULE18: six reset cause flags, one per source
// RULE19: illegal address flag only on fetches
// RULE20: registers at fe00, fe01, fe03
// RULE21: other resets set own flag, keep rest
package slb_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam int          ADDR_W          = 18;
  localparam logic [15:0] IDX_BREAK_EXIT  = 16'hfe00;
  localparam logic [15:0] IDX_RESET_CAUSE = 16'hfe01;
  localparam logic [15:0] IDX_BREAK_CTRL  = 16'hfe03;
  localparam logic [15:0] IDX_CONFIG_ONE  = 16'hfe08;

  // field positions
  localparam int BIT_BREAK_EXIT   = 1;
  localparam int BIT_CLEAR_ENABLE = 7;
  localparam int BIT_SHORT_REC    = 0;
  localparam int BIT_WDOG_DIS     = 1;

  // values after reset
  localparam logic [7:0] RST_BREAK_CTRL = 8'h00;
  localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
  localparam logic [7:0] POR_CAUSE      = 8'h80;

  // stop recovery lengths in internal oscillator cycles (= CLK_SYS cycles)
  localparam int          CNT_W         = 13;
  localparam logic [12:0] REC_LONG_CYC  = 13'h1000;
  localparam logic [12:0] REC_SHORT_CYC = 13'h0020;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {LP_RUN, LP_WAIT, LP_STOP, LP_RECOVER} slb_lp_state_t;

  // reset sources other than power-on and the pin, from on-chip logic
  typedef struct packed {
    logic wdog;
    logic ill_opcode;
    logic ill_addr;
    logic opcode_fetch;
    logic low_volt;
  } slb_rst_src_t;

  // reset-cause register layout, bit 7 down to bit 0
  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic ill_opcode;
    logic ill_addr;
    logic rsvd2;
    logic low_volt;
    logic rsvd0;
  } slb_cause_t;

endpackage : slb_pkg

// ===== verilog/slb_top.sv
module slb_top (
  input  wire logic                        CLK_SYS,
  input  wire logic                        RESET,
  input  wire logic [slb_pkg::ADDR_W-1:0]  AVS_ADDRESS,
  input  wire logic                        AVS_READ,
  input  wire logic                        AVS_WRITE,
  input  wire logic [31:0]                 AVS_WRITEDATA,
  input  wire logic [3:0]                  AVS_BYTEENABLE,
  output logic      [31:0]                 AVS_READDATA,
  output logic                             AVS_WAITREQUEST,
  input  wire logic                        CPU_WAIT_EXEC,
  input  wire logic                        CPU_STOP_EXEC,
  input  wire logic                        MODULE_IRQ,
  input  wire logic                        BREAK_IRQ,
  input  wire logic                        BREAK_ACTIVE,
  input  wire logic [7:0]                  CLEAR_REQ,
  output logic      [7:0]                  CLEAR_GNT,
  input  wire logic                        POR_EVENT,
  input  wire logic                        RST_PIN_N,
  input  wire slb_pkg::slb_rst_src_t       RST_SRC,
  output logic                             CPU_CLK_EN,
  output logic                             PERIPH_CLK_EN,
  output logic                             CLK_GEN_OUT_EN,
  output logic                             IMASK_CLEAR,
  output logic                             STACK_START,
  output logic                             WDOG_ENABLE
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  slb_pkg::slb_lp_state_t         state_q;
  slb_pkg::slb_lp_state_t         state_d;
  slb_pkg::slb_cause_t            cause_q;
  logic [slb_pkg::CNT_W-1:0]      cnt_q;
  logic [slb_pkg::CNT_W-1:0]      rec_len;
  logic                           rec_done;
  logic                           wake;
  logic                           exit_flag_q;
  logic [7:0]                     brk_ctrl_q;
  logic [7:0]                     config_q;
  logic                           pin_meta_q;
  logic                           pin_sync_q;
  logic                           bus_req;
  logic                           bus_fire;
  logic                           clear_ok;
  logic [7:0]                     rd_byte;

  // word decode, shared by read mux and write paths
  function automatic logic hit(input logic [slb_pkg::ADDR_W-1:0] addr,
                               input logic [15:0]                idx);
    hit = (addr[1:0] == 2'h0) && (addr[slb_pkg::ADDR_W-1:2] == idx);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then answer for exactly one cycle
  assign bus_req  = AVS_READ || AVS_WRITE;
  assign bus_fire = bus_req && !AVS_WAITREQUEST;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !(bus_req && AVS_WAITREQUEST);
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit(AVS_ADDRESS, slb_pkg::IDX_BREAK_EXIT)) begin
      rd_byte[slb_pkg::BIT_BREAK_EXIT] = exit_flag_q;
    end else if (hit(AVS_ADDRESS, slb_pkg::IDX_RESET_CAUSE)) begin // [RULE20]
      rd_byte = cause_q;
    end else if (hit(AVS_ADDRESS, slb_pkg::IDX_BREAK_CTRL)) begin
      rd_byte = brk_ctrl_q;
    end else if (hit(AVS_ADDRESS, slb_pkg::IDX_CONFIG_ONE)) begin
      rd_byte = config_q;
    end
  end

  // data latched on the edge that drops waitrequest, so it stands with it
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && AVS_WAITREQUEST) begin
      AVS_READDATA <= {24'h00_0000, rd_byte};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers: break flag control and configuration
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      brk_ctrl_q <= slb_pkg::RST_BREAK_CTRL;
      config_q   <= slb_pkg::RST_CONFIG_ONE;
    end else if (bus_fire && AVS_WRITE && AVS_BYTEENABLE[0]) begin
      if (hit(AVS_ADDRESS, slb_pkg::IDX_BREAK_CTRL)) begin
        brk_ctrl_q <= AVS_WRITEDATA[7:0];
      end
      if (hit(AVS_ADDRESS, slb_pkg::IDX_CONFIG_ONE)) begin
        config_q <= AVS_WRITEDATA[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status-flag protection; a clear lost in break is never replayed later,
  // and a second step after break sees the open gate and clears as normal
  assign clear_ok = !BREAK_ACTIVE || brk_ctrl_q[slb_pkg::BIT_CLEAR_ENABLE]; // [RULE1]

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CLEAR_GNT <= 8'h00;
    end else begin
      CLEAR_GNT <= CLEAR_REQ & {8{clear_ok}}; // [RULE1] [RULE2] [RULE3]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // low-power sequencer
  assign wake     = MODULE_IRQ || BREAK_IRQ;
  assign rec_len  = config_q[slb_pkg::BIT_SHORT_REC] ? slb_pkg::REC_SHORT_CYC
                                                     : slb_pkg::REC_LONG_CYC; // [RULE12]
  assign rec_done = (cnt_q == rec_len - 13'h0001);

  // reset itself returns to run, which is the reset exit from wait/stop
  always_comb begin
    state_d = state_q;
    case (state_q)
      slb_pkg::LP_RUN: begin
        if (CPU_STOP_EXEC) begin
          state_d = slb_pkg::LP_STOP;
        end else if (CPU_WAIT_EXEC) begin
          state_d = slb_pkg::LP_WAIT;
        end
      end
      slb_pkg::LP_WAIT: begin
        if (wake) begin
          state_d = slb_pkg::LP_RUN; // [RULE7]
        end
      end
      slb_pkg::LP_STOP: begin
        if (wake) begin
          state_d = slb_pkg::LP_RECOVER; // [RULE11]
        end
      end
      slb_pkg::LP_RECOVER: begin
        if (rec_done) begin
          state_d = slb_pkg::LP_RUN;
        end
      end
      default: begin
        state_d = slb_pkg::LP_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_q <= slb_pkg::LP_RUN; // [RULE7]
    end else begin
      state_q <= state_d;
    end
  end

  // clock gating follows the next state so the gates align with state_q
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CPU_CLK_EN     <= 1'b1;
      PERIPH_CLK_EN  <= 1'b1;
      CLK_GEN_OUT_EN <= 1'b1;
    end else begin
      CPU_CLK_EN     <= (state_d == slb_pkg::LP_RUN); // [RULE5]
      PERIPH_CLK_EN  <= (state_d == slb_pkg::LP_RUN) || (state_d == slb_pkg::LP_WAIT);
      CLK_GEN_OUT_EN <= (state_d == slb_pkg::LP_RUN) || (state_d == slb_pkg::LP_WAIT); // [RULE10]
    end
  end

  // recovery counter; zero through stop so recovery always starts clean
  always_ff @(posedge CLK_SYS) begin
    if (RESET || (state_q != slb_pkg::LP_RECOVER)) begin
      cnt_q <= '0; // [RULE10] [RULE13]
    end else begin
      cnt_q <= cnt_q + 13'h0001; // [RULE13]
    end
  end

  // cpu-side pulses: mask clear on entry, stacking on wait wake or at recovery end
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      IMASK_CLEAR <= 1'b0;
      STACK_START <= 1'b0;
    end else begin
      IMASK_CLEAR <= (state_q == slb_pkg::LP_RUN) && (CPU_WAIT_EXEC || CPU_STOP_EXEC); // [RULE4]
      STACK_START <= ((state_q == slb_pkg::LP_WAIT) && wake)              // [RULE6]
                   || ((state_q == slb_pkg::LP_RECOVER) && rec_done);     // [RULE11]
    end
  end

  // watchdog enable follows only the disable bit, so it stays on through wait unless BIT_WDOG_DIS is set
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      WDOG_ENABLE <= 1'b1;
    end else begin
      WDOG_ENABLE <= !config_q[slb_pkg::BIT_WDOG_DIS]; // [RULE9]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // break exit flag; set beats a same-cycle software clear
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      exit_flag_q <= 1'b0; // [RULE15]
    end else if (BREAK_IRQ && ((state_q == slb_pkg::LP_WAIT)
                               || (state_q == slb_pkg::LP_STOP))) begin
      exit_flag_q <= 1'b1; // [RULE8]
    end else if (bus_fire && AVS_WRITE && AVS_BYTEENABLE[0]
                 && hit(AVS_ADDRESS, slb_pkg::IDX_BREAK_EXIT)
                 && !AVS_WRITEDATA[slb_pkg::BIT_BREAK_EXIT]) begin
      exit_flag_q <= 1'b0; // [RULE15]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset pin synchroniser, second stage only is read
  always_ff @(posedge CLK_SYS) begin
    pin_meta_q <= RST_PIN_N;
    pin_sync_q <= pin_meta_q;
  end

  // reset-cause log; not cleared by RESET since sources raise RESET themselves
  always_ff @(posedge CLK_SYS) begin
    if (POR_EVENT) begin
      cause_q <= slb_pkg::POR_CAUSE; // [RULE17]
    end else begin
      if (bus_fire && AVS_READ && hit(AVS_ADDRESS, slb_pkg::IDX_RESET_CAUSE)) begin
        cause_q <= '0; // [RULE16]
      end
      // later assignments win, so a new cause survives a same-cycle read
      if (!pin_sync_q) begin
        cause_q.pin <= 1'b1; // [RULE18] [RULE21]
      end
      if (RST_SRC.wdog) begin
        cause_q.wdog <= 1'b1; // [RULE18]
      end
      if (RST_SRC.ill_opcode) begin
        cause_q.ill_opcode <= 1'b1; // [RULE18]
      end
      if (RST_SRC.ill_addr && RST_SRC.opcode_fetch) begin
        cause_q.ill_addr <= 1'b1; // [RULE19]
      end
      if (RST_SRC.low_volt) begin
        cause_q.low_volt <= 1'b1; // [RULE18]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_wait_gates_cpu: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (state_q == slb_pkg::LP_WAIT) |-> (!CPU_CLK_EN && PERIPH_CLK_EN)) // [RULE5]
    else $error("wait must gate cpu clock only");

  a_stop_clocks_off: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (state_q == slb_pkg::LP_STOP) |-> (!CLK_GEN_OUT_EN && !PERIPH_CLK_EN && cnt_q == '0)) // [RULE10]
    else $error("stop must disable clock output and clear counter");

  a_mask_clear_entry: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ((state_q == slb_pkg::LP_RUN) && (CPU_WAIT_EXEC || CPU_STOP_EXEC))
      |=> (IMASK_CLEAR && state_q != slb_pkg::LP_RUN)) // [RULE4]
    else $error("low-power entry must clear interrupt mask");

  a_wait_irq_stack: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ((state_q == slb_pkg::LP_WAIT) && MODULE_IRQ)
      |=> (STACK_START && CPU_CLK_EN && state_q == slb_pkg::LP_RUN)) // [RULE6]
    else $error("wait wake must stack next cycle");

  a_wait_break_exit: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ((state_q == slb_pkg::LP_WAIT) && BREAK_IRQ) |=> (state_q == slb_pkg::LP_RUN)) // [RULE7]
    else $error("break must leave wait");

  a_break_exit_flag: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (BREAK_IRQ && (state_q == slb_pkg::LP_WAIT || state_q == slb_pkg::LP_STOP))
      |=> exit_flag_q) // [RULE8]
    else $error("break exit must set flag");

  // the recovery counter itself measures the span, so no long repetition is unrolled
  a_short_recovery: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ((state_q == slb_pkg::LP_RECOVER) && config_q[slb_pkg::BIT_SHORT_REC]
      && cnt_q == 13'h001f) |=> (STACK_START && state_q == slb_pkg::LP_RUN)) // [RULE12]
    else $error("short recovery must stack after 32 cycles");

  a_long_recovery: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ((state_q == slb_pkg::LP_RECOVER) && !config_q[slb_pkg::BIT_SHORT_REC]
      && cnt_q < 13'h0fff) |=> !STACK_START) // [RULE11]
    else $error("no stacking before long recovery ends");

  a_guard_clear: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (BREAK_ACTIVE && !brk_ctrl_q[slb_pkg::BIT_CLEAR_ENABLE]) |=> (CLEAR_GNT == 8'h00)) // [RULE1]
    else $error("flag clear leaked during protected break");

  a_wdog_enable: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (state_q == slb_pkg::LP_WAIT && !config_q[slb_pkg::BIT_WDOG_DIS]) |-> WDOG_ENABLE) // [RULE9]
    else $error("watchdog must run in wait");

  a_por_only: assert property (@(posedge CLK_SYS)
    POR_EVENT |=> (cause_q == slb_pkg::POR_CAUSE)) // [RULE17]
    else $error("power-on must set only its own flag");

  a_cause_read_clr: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (bus_fire && AVS_READ && hit(AVS_ADDRESS, slb_pkg::IDX_RESET_CAUSE) && !POR_EVENT
      && pin_sync_q && RST_SRC == '0) |=> (cause_q == '0)) // [RULE16]
    else $error("reading reset cause must clear it");

  a_exit_flag_reset: assert property (@(posedge CLK_SYS)
    RESET |=> !exit_flag_q) // [RULE15]
    else $error("reset must clear break exit flag");

  c_wait_irq_wake: cover property (@(posedge CLK_SYS) disable iff (RESET)
    (state_q == slb_pkg::LP_WAIT) ##1 STACK_START);

  c_stop_recovered: cover property (@(posedge CLK_SYS) disable iff (RESET)
    (state_q == slb_pkg::LP_RECOVER) && rec_done);

  c_break_in_stop: cover property (@(posedge CLK_SYS) disable iff (RESET)
    (state_q == slb_pkg::LP_STOP) && BREAK_IRQ);

endmodule : slb_top

// ===== verif/slb_partner.sv
// cpu core, break module and peripherals as seen from the unit
module slb_partner (
  input  wire logic       clk,
  input  wire logic       cpu_clk_en,
  output logic            wait_exec,
  output logic            stop_exec,
  output logic            irq,
  output logic            brk_irq,
  output logic            brk_act,
  output logic [7:0]      clr_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {wait_exec, stop_exec, irq, brk_irq, brk_act} = 5'h00;
    clr_req = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one-cycle strobe: 0 wait, 1 stop, 2 module irq, 3 break irq
  // the core only executes instructions while its clock runs
  task automatic fire(input int k);
    if (k < 2 && cpu_clk_en !== 1'b1) return;
    case (k)
      0: wait_exec <= 1'b1;
      1: stop_exec <= 1'b1;
      2: irq <= 1'b1;
      default: brk_irq <= 1'b1;
    endcase
    @(posedge clk);
    {wait_exec, stop_exec, irq, brk_irq} <= 4'h0;
  endtask : fire

  // peripheral clear attempt, optionally while the core sits in break
  task automatic attempt(input logic [7:0] m, input logic b);
    clr_req <= m;
    brk_act <= b;
    @(posedge clk);
    clr_req <= 8'h00;
    brk_act <= 1'b0;
  endtask : attempt
endmodule : slb_partner

// ===== verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        clk, reset, rd_s, wr_s, wreq, pin_n, por;
  logic [slb_pkg::ADDR_W-1:0]  addr;
  logic [31:0]                 wdat, rdat;
  logic [3:0]                  be;
  logic [7:0]                  creq, cgnt, rd;
  logic                        wx, sx, irq, bi, ba, cpu_en, per_en, cg_en, imask, stk, wdog;
  slb_pkg::slb_rst_src_t       src;
  int                          failures, cmp_count, m_cause;

  slb_top u_dut (.CLK_SYS(clk), .RESET(reset), .AVS_ADDRESS(addr), .AVS_READ(rd_s),
    .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .CPU_WAIT_EXEC(wx), .CPU_STOP_EXEC(sx), .MODULE_IRQ(irq),
    .BREAK_IRQ(bi), .BREAK_ACTIVE(ba), .CLEAR_REQ(creq), .CLEAR_GNT(cgnt),
    .POR_EVENT(por), .RST_PIN_N(pin_n), .RST_SRC(src), .CPU_CLK_EN(cpu_en),
    .PERIPH_CLK_EN(per_en), .CLK_GEN_OUT_EN(cg_en), .IMASK_CLEAR(imask),
    .STACK_START(stk), .WDOG_ENABLE(wdog));
  slb_partner u_part (.clk(clk), .cpu_clk_en(cpu_en), .wait_exec(wx), .stop_exec(sx),
    .irq(irq), .brk_irq(bi), .brk_act(ba), .clr_req(creq));

  always #10 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input bit w, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    addr <= {idx, 2'b00};
    wdat <= {24'($urandom), wd}; // upper bytes are ignored by the slave
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    rd = rdat[7:0];
    if (n >= 20) failures++;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input string what);
    bus(1'b0, idx, 8'h00);
    chk(what, {8'h00, rd}, {8'h00, exp});
  endtask : rdc

  task automatic pulse_reset();
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask : pulse_reset

  // stop entry, wake by event k, count edges until stacking starts
  task automatic stop_run(input logic [7:0] cfg, input int k, input int n_exp);
    int n;
    bus(1'b1, slb_pkg::IDX_CONFIG_ONE, cfg);
    u_part.fire(1);
    @(posedge clk);
    chk("stop_clocks", 16'({cg_en, per_en, cpu_en, imask}), 16'h0001);
    repeat (3) @(posedge clk);
    u_part.fire(k);
    n = 1;
    while (stk !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("recovery", 16'(n), 16'(n_exp));
  endtask : stop_run

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  //////////////////////////////////////////////////////////////////////////////
  // hang guard, well above the longest recovery plus traffic
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    summarize();
  end

  // source table: expected cause bits follow the register layout
  slb_pkg::slb_rst_src_t src_t [5] = '{5'h10, 5'h08, 5'h06, 5'h04, 5'h01};
  logic [7:0]            exp_t [5] = '{8'h20, 8'h10, 8'h08, 8'h00, 8'h02};

  initial begin
    {clk, rd_s, wr_s, src} = '0;
    {reset, pin_n, por} = 3'h7;
    addr = '0;
    wdat = '0;
    be = 4'hf;
    failures = 0;
    cmp_count = 0;
    void'($urandom(32'h0157));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    m_cause = 8'h80;
    rdc(slb_pkg::IDX_RESET_CAUSE, 8'(m_cause), "cause_por");
    rdc(slb_pkg::IDX_RESET_CAUSE, 8'h00, "cause_read");
    rdc(slb_pkg::IDX_BREAK_CTRL, slb_pkg::RST_BREAK_CTRL, "ctrl_rst");
    rdc(16'hfe02, 8'h00, "unmapped");
    rdc(slb_pkg::IDX_BREAK_EXIT, 8'h00, "exit_rst");
    $display("registers test done");
    // each on-chip source alone; ill_addr without a fetch must not count
    for (int k = 0; k < 5; k++) begin
      src <= src_t[k];
      @(posedge clk);
      src <= '0;
      @(posedge clk);
      rdc(slb_pkg::IDX_RESET_CAUSE, exp_t[k], "cause_src");
    end
    // two sources in a row accumulate until read
    src <= 5'h10;
    pin_n <= 1'b0;
    @(posedge clk);
    src <= '0;
    repeat (2) @(posedge clk);
    pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(slb_pkg::IDX_RESET_CAUSE, 8'h60, "cause_keep");
    $display("reset cause test done");
    // random clear attempts, with and without break, enable off then on
    for (int i = 0; i < 12; i++) begin
      logic [7:0] m;
      m = 8'($urandom);
      if (i == 6) bus(1'b1, slb_pkg::IDX_BREAK_CTRL, 8'h80);
      u_part.attempt(m, i[0]);
      @(posedge clk);
      chk("grant", 16'(cgnt), 16'((i[0] && i < 6) ? 8'h00 : m));
    end
    rdc(slb_pkg::IDX_BREAK_CTRL, 8'h80, "ctrl_rw");
    $display("break protection test done");
    // wait entry and wake by module interrupt
    u_part.fire(0);
    @(posedge clk);
    chk("wait_enter", 16'({imask, cpu_en, per_en, wdog}), 16'h000b);
    u_part.fire(2);
    @(posedge clk);
    chk("wait_wake", 16'({stk, cpu_en}), 16'h0003);
    // wait left by break, flag set then cleared by writing zero
    u_part.fire(0);
    @(posedge clk);
    u_part.fire(3);
    @(posedge clk);
    chk("wait_brk", 16'(cpu_en), 16'h0001);
    rdc(slb_pkg::IDX_BREAK_EXIT, 8'h02, "exit_wait");
    bus(1'b1, slb_pkg::IDX_BREAK_EXIT, 8'h00);
    rdc(slb_pkg::IDX_BREAK_EXIT, 8'h00, "exit_wr0");
    // wait left by reset
    u_part.fire(0);
    @(posedge clk);
    pulse_reset();
    chk("wait_rst", 16'(cpu_en), 16'h0001);
    $display("wait test done");
    stop_run(8'h01, 2, 34);
    stop_run(8'h00, 2, 4098);
    stop_run(8'h01, 3, 34);
    rdc(slb_pkg::IDX_BREAK_EXIT, 8'h02, "exit_stop");
    pulse_reset();
    rdc(slb_pkg::IDX_BREAK_EXIT, 8'h00, "exit_reset");
    $display("stop test done");
    // watchdog disable: low byte not enabled means the write is dropped
    be <= 4'he;
    bus(1'b1, slb_pkg::IDX_CONFIG_ONE, 8'h02);
    chk("wdog_be", 16'(wdog), 16'h0001);
    be <= 4'hf;
    bus(1'b1, slb_pkg::IDX_CONFIG_ONE, 8'h02);
    @(posedge clk); // enable output is registered one edge after the config write
    chk("wdog_dis", 16'(wdog), 16'h0000);
    $display("watchdog test done");
    summarize();
  end
endmodule : tb
